// ### design/dbg_consts.svh
// constants of the debug port front end: timing counts, switch patterns, instruction codes
// assumes it is included by bare name from files that need the values
//
// What this block does
// (RULE_01) non-clock debug pins stay general-purpose until a probe is detected
// (RULE_02) in serial-wire mode TDI and TDO are released; TDO may carry trace
// (RULE_03) hot-plug detection works in every power state except backup mode
// (RULE_04) an attached probe keeps the link alive and forbids power-off
// (RULE_05) port logic advances only on test clock edges the probe supplies
// (RULE_06) an access-port access asks the power manager to restore CPU clock
// (RULE_07) while external reset is held, the RC oscillator clocks the CPU
// (RULE_08) first test clock falling edge outside external reset marks probe attached
// (RULE_09) port logic is synchronously reset while the TAP sits in Test-Logic-Reset
// (RULE_10) probe should hold TMS high five clocks after detection
// (RULE_11) on detection the debug function takes the pins from any peripheral, no reset
// (RULE_12) attaching leaves the processor running undisturbed
// (RULE_13) test clock held low through external reset requests core held in reset
// (RULE_14) system manager access port may withdraw the core reset request
// (RULE_15) after reset the port starts in JTAG mode
// (RULE_16) over 50 ones, 0x79E7 MSB first, over 50 ones switches to serial wire
// (RULE_17) over 50 ones, 0x3CE7 MSB first, over 50 ones switches back to JTAG
// (RULE_18) boundary-scan TAP is unavailable in serial-wire mode
// (RULE_19) trace on TDO only in serial-wire mode, never in JTAG
// (RULE_20) access port select 0 routes to bus memory port, 1 to system manager
// (RULE_21) in JTAG both TAPs run together and capture every instruction
// (RULE_22) TDO follows boundary-scan TAP when it recognises its instruction, else debug TAP
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH

// ----------------------------------------------------------------
// switching sequence
// ----------------------------------------------------------------
`define SEQ_ONES_MIN 6'd51
`define SEQ_PAT_LAST 4'hE // lead state already takes the first pattern bit
`define SEQ_TO_SWD 16'h79E7
`define SEQ_TO_JTAG 16'h3CE7

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define IR_RESET_VAL 4'hE
`define IR_CAPTURE_VAL 4'h1
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_INTEST 4'h4
`define IR_CLAMP 4'h5

// ----------------------------------------------------------------
// access port select
// ----------------------------------------------------------------
`define ACCESS_PORT_SELECT_BUS_MEM 8'h00
`define ACCESS_PORT_SELECT_SYS_MGR 8'h01

`endif

// ### design/dbg_pkg.sv
// types shared by the debug port front end files
// assumes nothing beyond a SystemVerilog compiler
package dbg_pkg;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR = 4'hF
  } tap_state_type;

  typedef enum logic [1:0] {
    SEQ_LEAD = 2'h0,
    SEQ_PATTERN = 2'h1,
    SEQ_TAIL = 2'h2
  } seq_state_type;

  typedef enum logic {
    PORT_JTAG = 1'b0,
    PORT_SWD = 1'b1
  } port_mode_type;

  // ----------------------------------------------------------------
  // grouped outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tms_owned;
    logic tdi_owned;
    logic tdo_owned;
    logic trace_on_tdo;
  } pin_owner_type;

  typedef struct packed {
    logic bus_mem_sel;
    logic sys_mgr_sel;
  } ap_route_type;

  typedef struct packed {
    logic keep_power_on;
    logic cpu_clk_restore_req;
    logic system_rc_oscillator_clock_as_cpu_clk;
    logic core_reset_req;
  } sys_ctrl_type;

endpackage : dbg_pkg

// ### design/pin_sampler.sv
// two-flop synchroniser for one pin with rise and fall pulses
// assumes the pin is asynchronous to ref_clk and changes slower than ref_clk
`timescale 1ns/10ps
`default_nettype none

module pin_sampler (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_ff;
  logic sync_ff;
  logic hist_ff;

  // ----------------------------------------------------------------
  // synchroniser; meta_ff is read only by sync_ff
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      hist_ff <= 1'b0;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  // edges come from the settled copies only
  assign level = sync_ff;
  assign rise = sync_ff & ~hist_ff;
  assign fall = ~sync_ff & hist_ff;

endmodule // pin_sampler

`default_nettype wire

// ### design/enhanced_debug_front_end.sv
// debug port front end: probe detection, pin hand-over, JTAG/serial-wire switch, TDO select
// assumes tck, tms, tdi and reset_n arrive as raw pins; other inputs are on ref_clk
`timescale 1ns/10ps
`default_nettype none

`include "dbg_consts.svh"

module enhanced_debug_front_end (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  input wire logic reset_n_pin,
  input wire logic backup_mode,
  input wire logic dp_swdio_out,
  input wire logic dp_swdio_oe,
  input wire logic dp_tdo,
  input wire logic bscan_tdo,
  input wire logic trace_data,
  input wire logic trace_enable,
  input wire logic dp_ap_access,
  input wire logic ap_req,
  input wire logic [7:0] access_port_select,
  input wire logic system_manager_access_port_release_core,
  output dbg_pkg::pin_owner_type pin_owner,
  output dbg_pkg::port_mode_type port_mode,
  output dbg_pkg::tap_state_type tap_state,
  output dbg_pkg::ap_route_type ap_route,
  output dbg_pkg::sys_ctrl_type sys_ctrl,
  output logic debugger_attached,
  output logic tap_logic_reset,
  output logic bscan_enable,
  output logic bscan_selected,
  output logic [3:0] instruction,
  output logic swdio_out,
  output logic swdio_oe,
  output logic tdo_out,
  output logic tdo_oe
);

  import dbg_pkg::*;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic tck_level;
  logic tck_rise;
  logic tck_fall;
  logic tms_level;
  logic tdi_level;
  logic rst_pin_level;
  logic rst_pin_rise;
  logic rst_pin_fall;

  // the test clock is only sampled, so every port action is a tck edge seen here
  pin_sampler u_tck (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin(tck_pin),
    .level(tck_level),
    .rise(tck_rise),
    .fall(tck_fall)
  ); // RULE_05

  // tms and tdi share the tck latency, so they line up with the tck edge pulses
  pin_sampler u_tms (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin(tms_pin),
    .level(tms_level),
    .rise(),
    .fall()
  );

  pin_sampler u_tdi (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin(tdi_pin),
    .level(tdi_level),
    .rise(),
    .fall()
  );

  pin_sampler u_rst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin(reset_n_pin),
    .level(rst_pin_level),
    .rise(rst_pin_rise),
    .fall(rst_pin_fall)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic attached_ff;
  logic tck_held_low_ff;
  logic core_hold_ff;
  tap_state_type tap_ff;
  tap_state_type nxt_tap;
  logic [3:0] ir_shift_ff;
  logic [3:0] ir_ff;
  seq_state_type seq_ff;
  seq_state_type nxt_seq;
  logic [5:0] ones_ff;
  logic [5:0] nxt_ones;
  logic [15:0] pat_ff;
  logic [3:0] bit_cnt_ff;
  port_mode_type mode_ff;
  port_mode_type nxt_mode;
  pin_owner_type owner_ff;
  ap_route_type route_ff;
  sys_ctrl_type sys_ff;
  logic swdio_out_ff;
  logic swdio_oe_ff;
  logic tdo_out_ff;
  logic tdo_oe_ff;

  // ----------------------------------------------------------------
  // probe detection and core hold
  // ----------------------------------------------------------------
  wire detect_ok = ~backup_mode; // RULE_03
  wire attach_evt = detect_ok & rst_pin_level & tck_fall & ~attached_ff; // RULE_08
  wire hold_evt = rst_pin_rise & tck_held_low_ff; // RULE_13

  // attach never touches the processor; only the pins and power change
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      attached_ff <= 1'b0;
    end else if (attach_evt) begin
      attached_ff <= 1'b1; // RULE_08 RULE_12
    end
  end

  // tck must stay low across the whole external reset for the hold to arm
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tck_held_low_ff <= 1'b0;
    end else if (rst_pin_fall) begin
      tck_held_low_ff <= ~tck_level; // RULE_13
    end else if (!rst_pin_level && tck_level) begin
      tck_held_low_ff <= 1'b0; // RULE_13
    end
  end

  // set wins over a release that lands in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      core_hold_ff <= 1'b0;
    end else if (hold_evt) begin
      core_hold_ff <= 1'b1; // RULE_13
    end else if (system_manager_access_port_release_core) begin
      core_hold_ff <= 1'b0; // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // TAP controller, advanced on each tck rise once attached
  // ----------------------------------------------------------------
  always_comb begin
    nxt_tap = tap_ff;
    unique case (tap_ff)
      TAP_RESET: nxt_tap = tms_level ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nxt_tap = tms_level ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_tap = tms_level ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt_tap = tms_level ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nxt_tap = tms_level ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nxt_tap = tms_level ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nxt_tap = tms_level ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nxt_tap = tms_level ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: nxt_tap = tms_level ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt_tap = tms_level ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: nxt_tap = tms_level ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nxt_tap = tms_level ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nxt_tap = tms_level ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nxt_tap = tms_level ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nxt_tap = tms_level ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: nxt_tap = tms_level ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  wire tap_step = attached_ff & tck_rise; // RULE_05
  wire in_tlr = (tap_ff == TAP_RESET);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tap_ff <= TAP_RESET;
    end else if (tap_step) begin
      tap_ff <= nxt_tap;
    end
  end

  // ----------------------------------------------------------------
  // shared instruction register; both TAPs see the same shifted code
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ir_shift_ff <= `IR_RESET_VAL;
      ir_ff <= `IR_RESET_VAL;
    end else if (in_tlr) begin
      ir_shift_ff <= `IR_RESET_VAL; // RULE_09
      ir_ff <= `IR_RESET_VAL; // RULE_09
    end else if (tap_step && tap_ff == TAP_CAP_IR) begin
      ir_shift_ff <= `IR_CAPTURE_VAL;
    end else if (tap_step && tap_ff == TAP_SHIFT_IR) begin
      ir_shift_ff <= {tdi_level, ir_shift_ff[3:1]}; // RULE_21
    end else if (attached_ff && tck_fall && tap_ff == TAP_UPD_IR) begin
      ir_ff <= ir_shift_ff; // RULE_21
    end
  end

  // ----------------------------------------------------------------
  // mode switching sequence detector
  // ----------------------------------------------------------------
  // it ignores Test-Logic-Reset on purpose: the long TMS-high runs of the
  // sequence always park the TAP there, so a TLR reset would kill the switch
  wire lead_done = (ones_ff >= `SEQ_ONES_MIN);
  wire [15:0] pat_next = {pat_ff[14:0], tms_level};
  wire [15:0] pat_want = (mode_ff == PORT_JTAG) ? `SEQ_TO_SWD : `SEQ_TO_JTAG;
  wire pat_last = (bit_cnt_ff == `SEQ_PAT_LAST);
  wire [5:0] ones_inc = lead_done ? ones_ff : ones_ff + 6'd1;

  always_comb begin
    nxt_seq = seq_ff;
    nxt_ones = ones_ff;
    nxt_mode = mode_ff;
    unique case (seq_ff)
      SEQ_LEAD: begin
        if (tms_level) begin
          nxt_ones = ones_inc;
        end else if (lead_done) begin
          nxt_seq = SEQ_PATTERN;
          nxt_ones = 6'h00;
        end else begin
          nxt_ones = 6'h00;
        end
      end
      SEQ_PATTERN: begin
        if (pat_last) begin
          nxt_seq = (pat_next == pat_want) ? SEQ_TAIL : SEQ_LEAD; // RULE_16 RULE_17
          nxt_ones = {5'h00, tms_level & (pat_next != pat_want)};
        end
      end
      SEQ_TAIL: begin
        if (!tms_level) begin
          nxt_seq = SEQ_LEAD;
          nxt_ones = 6'h00;
        end else if (ones_inc == `SEQ_ONES_MIN) begin
          nxt_seq = SEQ_LEAD;
          nxt_ones = ones_inc;
          nxt_mode = (mode_ff == PORT_JTAG) ? PORT_SWD : PORT_JTAG; // RULE_16 RULE_17
        end else begin
          nxt_ones = ones_inc;
        end
      end
      default: begin
        nxt_seq = SEQ_LEAD;
        nxt_ones = 6'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seq_ff <= SEQ_LEAD;
      ones_ff <= 6'h00;
      mode_ff <= PORT_JTAG; // RULE_15
    end else if (tap_step) begin
      seq_ff <= nxt_seq;
      ones_ff <= nxt_ones;
      mode_ff <= nxt_mode;
    end
  end

  // pattern shift, MSB first; the counter restarts on entry to the pattern
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pat_ff <= 16'h0000;
      bit_cnt_ff <= 4'h0;
    end else if (tap_step) begin
      pat_ff <= pat_next;
      bit_cnt_ff <= (seq_ff == SEQ_PATTERN) ? bit_cnt_ff + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // decode and selection
  // ----------------------------------------------------------------
  wire jtag_on = attached_ff & (mode_ff == PORT_JTAG);
  wire swd_on = attached_ff & (mode_ff == PORT_SWD);
  wire ir_known = (ir_ff == `IR_EXTEST) | (ir_ff == `IR_SAMPLE) |
                  (ir_ff == `IR_INTEST) | (ir_ff == `IR_CLAMP);
  wire use_bscan = jtag_on & ir_known; // RULE_18 RULE_22
  wire trace_on = swd_on & trace_enable; // RULE_19
  wire sel_bus_mem = attached_ff & ap_req & (access_port_select == `ACCESS_PORT_SELECT_BUS_MEM); // RULE_20
  wire sel_sys_mgr = attached_ff & ap_req & (access_port_select == `ACCESS_PORT_SELECT_SYS_MGR); // RULE_20

  // pin owners: tms always once attached, tdi only in JTAG, tdo in JTAG or with serial-wire trace on
  wire pin_owner_type owner_d = '{
    tms_owned: attached_ff, // RULE_01 RULE_11
    tdi_owned: jtag_on, // RULE_02
    tdo_owned: jtag_on | trace_on, // RULE_02
    trace_on_tdo: trace_on // RULE_19
  };

  // power manager requests; the RC clock takes over during external reset
  wire sys_ctrl_type sys_d = '{
    keep_power_on: attached_ff, // RULE_04
    cpu_clk_restore_req: attached_ff & dp_ap_access, // RULE_06
    system_rc_oscillator_clock_as_cpu_clk: ~rst_pin_level, // RULE_07
    core_reset_req: core_hold_ff // RULE_13
  };

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      owner_ff <= '0;
      route_ff <= '0;
      sys_ff <= '0;
    end else begin
      owner_ff <= owner_d;
      route_ff <= '{bus_mem_sel: sel_bus_mem, sys_mgr_sel: sel_sys_mgr};
      sys_ff <= sys_d;
    end
  end

  // serial-wire data drive only in serial-wire mode; TDO mux one flop deep
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      swdio_out_ff <= 1'b0;
      swdio_oe_ff <= 1'b0;
      tdo_out_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      swdio_out_ff <= dp_swdio_out;
      swdio_oe_ff <= swd_on & dp_swdio_oe;
      tdo_out_ff <= trace_on ? trace_data : (use_bscan ? bscan_tdo : dp_tdo); // RULE_22 RULE_19
      tdo_oe_ff <= jtag_on | trace_on; // RULE_02
    end
  end

  assign pin_owner = owner_ff;
  assign port_mode = mode_ff;
  assign tap_state = tap_ff;
  assign ap_route = route_ff;
  assign sys_ctrl = sys_ff;
  assign debugger_attached = attached_ff;
  assign tap_logic_reset = in_tlr; // RULE_09
  assign bscan_enable = jtag_on; // RULE_18 RULE_21
  assign bscan_selected = use_bscan;
  assign instruction = ir_ff;
  assign swdio_out = swdio_out_ff;
  assign swdio_oe = swdio_oe_ff;
  assign tdo_out = tdo_out_ff;
  assign tdo_oe = tdo_oe_ff;

endmodule // enhanced_debug_front_end

`default_nettype wire

// ### verif/dbg_front_end_sva.sv
// checker for the debug port front end, bound to its top module
// assumes one ref_clk domain and an active-low asynchronous rstn
`timescale 1ns/10ps
`default_nettype none

module dbg_front_end_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reset_n_pin,
  input wire logic backup_mode,
  input wire logic dp_tdo,
  input wire logic bscan_tdo,
  input wire logic dp_ap_access,
  input wire logic ap_req,
  input wire logic [7:0] access_port_select,
  input wire logic system_manager_access_port_release_core,
  input wire dbg_pkg::pin_owner_type pin_owner,
  input wire dbg_pkg::port_mode_type port_mode,
  input wire dbg_pkg::ap_route_type ap_route,
  input wire dbg_pkg::sys_ctrl_type sys_ctrl,
  input wire logic debugger_attached,
  input wire logic tap_logic_reset,
  input wire logic bscan_enable,
  input wire logic bscan_selected,
  input wire logic [3:0] instruction,
  input wire logic tdo_out
);
  import dbg_pkg::*;
  // ----
  // properties
  // ----
  // one domain; reset cancels every attempt in flight
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  property p_gpio; !$past(debugger_attached) |-> pin_owner == 4'h0; endproperty
  a_gpio: assert property (p_gpio) else $error("pins taken before attach");
  property p_swd_free; port_mode == PORT_SWD && $past(port_mode) == PORT_SWD |-> !pin_owner.tdi_owned; endproperty
  a_swd_free: assert property (p_swd_free) else $error("tdi held in serial wire");
  property p_backup; backup_mode && !debugger_attached |=> !debugger_attached; endproperty
  a_backup: assert property (p_backup) else $error("attach during backup");
  property p_power; $past(debugger_attached) |-> sys_ctrl.keep_power_on; endproperty
  a_power: assert property (p_power) else $error("power not kept");
  property p_no_tap; !debugger_attached |-> tap_logic_reset; endproperty
  a_no_tap: assert property (p_no_tap) else $error("tap moved before attach");
  property p_restore; $past(rstn) |-> sys_ctrl.cpu_clk_restore_req == $past(debugger_attached && dp_ap_access); endproperty
  a_restore: assert property (p_restore) else $error("clock restore wrong");
  property p_system_rc_oscillator_clock; !reset_n_pin [*5] |-> sys_ctrl.system_rc_oscillator_clock_as_cpu_clk; endproperty
  a_system_rc_oscillator_clock: assert property (p_system_rc_oscillator_clock) else $error("rc clock not chosen");
  property p_tlr; tap_logic_reset && $past(tap_logic_reset) |-> instruction == 4'hE; endproperty
  a_tlr: assert property (p_tlr) else $error("ir not held in reset");
  property p_attach; $rose(debugger_attached) |-> ##1 pin_owner.tms_owned && pin_owner.tdo_owned; endproperty
  a_attach: assert property (p_attach) else $error("pins not forced");
  property p_release; system_manager_access_port_release_core [*2] |=> !sys_ctrl.core_reset_req; endproperty
  a_release: assert property (p_release) else $error("core hold not withdrawn");
  property p_no_bscan; bscan_enable |-> port_mode == PORT_JTAG && debugger_attached; endproperty
  a_no_bscan: assert property (p_no_bscan) else $error("bscan in serial wire");
  property p_trace; pin_owner.trace_on_tdo |-> $past(port_mode) == PORT_SWD; endproperty
  a_trace: assert property (p_trace) else $error("trace in jtag");
  property p_route; $past(rstn && debugger_attached && ap_req) |->
    ap_route == {$past(access_port_select) == 8'h00, $past(access_port_select) == 8'h01}; endproperty
  a_route: assert property (p_route) else $error("access port route wrong");
  property p_tdo_sel; $past(rstn) && $past(port_mode) == PORT_JTAG |->
    tdo_out == ($past(bscan_selected) ? $past(bscan_tdo) : $past(dp_tdo)); endproperty
  a_tdo_sel: assert property (p_tdo_sel) else $error("tdo source wrong");
endmodule // dbg_front_end_sva

bind enhanced_debug_front_end dbg_front_end_sva i_sva (
  .ref_clk, .rstn, .reset_n_pin, .backup_mode, .dp_tdo, .bscan_tdo, .dp_ap_access, .ap_req,
  .access_port_select, .system_manager_access_port_release_core, .pin_owner, .port_mode, .ap_route, .sys_ctrl,
  .debugger_attached, .tap_logic_reset, .bscan_enable, .bscan_selected, .instruction, .tdo_out
);

`default_nettype wire

// ### verif/probe_model.sv
// external probe: drives test clock, mode select and data-in pins
// assumes the bench calls its tasks one at a time
`timescale 1ns/10ps
`default_nettype none

module probe_model (
  output var logic tck,
  output var logic tms,
  output var logic tdi
);
  // ----
  // link clock, 160 ns period, still between calls
  // ----
  initial begin
    tck = 1'h1;
    tms = 1'h1;
    tdi = 1'h0;
  end

  // pins change with the fall so the rise finds them settled
  task automatic cyc(input logic m, input logic d);
    tck = 1'h0;
    tms = m;
    tdi = d;
    #80;
    tck = 1'h1;
    #80;
  endtask

  task automatic stand(input logic lvl);
    tck = lvl;
  endtask

  // five ones park the tap before any scan
  task automatic to_tlr();
    repeat (5) cyc(1'h1, 1'h0);
  endtask

  // exactly 51 ones each side: the smallest count that is more than 50
  task automatic switch_mode(input logic [15:0] pat);
    repeat (51) cyc(1'h1, 1'h0);
    for (int i = 15; i >= 0; i--) cyc(pat[i], 1'h0);
    repeat (51) cyc(1'h1, 1'h0);
  endtask

  // idle, select-dr, select-ir, capture-ir, shift-ir, four bits lsb first, update
  task automatic load_ir(input logic [3:0] code);
    logic [4:0] path;
    path = 5'h06;
    to_tlr();
    for (int i = 0; i < 5; i++) cyc(path[i], 1'h0);
    for (int i = 0; i < 4; i++) cyc(i == 3, code[i]);
    cyc(1'h1, 1'h0);
    cyc(1'h0, 1'h0);
  endtask
endmodule // probe_model

`default_nettype wire

// ### verif/debug_port_attach_and_select_tb.sv
// bench for the debug port front end: probe model on the pins, checks at the ports
// assumes design files, probe model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none

module debug_port_attach_and_select_tb;
  import dbg_pkg::*;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic reset_n_pin = 1'h1;
  logic backup_mode, dp_swdio_out, dp_swdio_oe, dp_tdo, bscan_tdo, trace_data, trace_enable;
  logic dp_ap_access, ap_req, system_manager_access_port_release_core;
  logic [7:0] access_port_select;
  wire logic tck_pin, tms_pin, tdi_pin;
  pin_owner_type pin_owner;
  port_mode_type port_mode;
  tap_state_type tap_state;
  ap_route_type ap_route;
  sys_ctrl_type sys_ctrl;
  logic debugger_attached, tap_logic_reset, bscan_enable, bscan_selected, swdio_out, swdio_oe, tdo_out, tdo_oe;
  logic [3:0] instruction;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  probe_model i_probe (.tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin));

  enhanced_debug_front_end i_dut (
    .ref_clk, .rstn, .tck_pin, .tms_pin, .tdi_pin, .reset_n_pin, .backup_mode, .dp_swdio_out,
    .dp_swdio_oe, .dp_tdo, .bscan_tdo, .trace_data, .trace_enable, .dp_ap_access, .ap_req,
    .access_port_select, .system_manager_access_port_release_core, .pin_owner, .port_mode, .tap_state, .ap_route,
    .sys_ctrl, .debugger_attached, .tap_logic_reset, .bscan_enable, .bscan_selected,
    .instruction, .swdio_out, .swdio_oe, .tdo_out, .tdo_oe
  );

  // ----
  // clock, watchdog, helpers
  // ----
  always #10 ref_clk = ~ref_clk;

  // whole run needs about 3800 cycles; 20000 leaves room for slow edges
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic wclk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected value at %0t: seen %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_attach();
    chk(port_mode, PORT_JTAG);
    chk(instruction, 4'hE);
    backup_mode = 1'h1;
    i_probe.cyc(1'h1, 1'h0);
    wclk(6);
    chk(debugger_attached, 1'h0);
    chk(pin_owner, 4'h0);
    backup_mode = 1'h0;
    i_probe.cyc(1'h1, 1'h0);
    wclk(6);
    chk(debugger_attached, 1'h1);
    chk(pin_owner, 4'hE);
    chk(tdo_oe, 1'h1);
    chk(tap_logic_reset, 1'h1);
    chk(tap_state, TAP_RESET);
    chk(sys_ctrl.keep_power_on, 1'h1);
    chk(sys_ctrl.core_reset_req, 1'h0);
  endtask

  // recognised codes hand tdo to the boundary-scan side, others to the debug side
  task automatic t_tdo_select();
    logic [3:0] codes [6];
    codes = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'hB};
    bscan_tdo = 1'h1;
    for (int i = 0; i < 6; i++) begin
      i_probe.load_ir(codes[i]);
      wclk(6);
      chk(instruction, codes[i]);
      chk(tdo_out, i < 4);
      chk(bscan_selected, i < 4);
    end
    i_probe.to_tlr();
    wclk(6);
    chk(instruction, 4'hE);
  endtask

  task automatic t_switch();
    i_probe.switch_mode(16'h3CE7);
    wclk(8);
    chk(port_mode, PORT_JTAG);
    i_probe.switch_mode(16'h79E7);
    wclk(8);
    chk(port_mode, PORT_SWD);
    chk(pin_owner.tdi_owned, 1'h0);
    chk(bscan_enable, 1'h0);
    chk(tdo_oe, 1'h0);
    dp_swdio_out = 1'h1;
    dp_swdio_oe = 1'h1;
    trace_enable = 1'h1;
    trace_data = 1'h1;
    wclk(3);
    chk(tdo_out, 1'h1);
    chk(pin_owner.trace_on_tdo, 1'h1);
    chk(swdio_oe, 1'h1);
    chk(swdio_out, 1'h1);
    chk(tdo_oe, 1'h1);
    i_probe.switch_mode(16'h3CE7);
    wclk(8);
    chk(port_mode, PORT_JTAG);
    chk(pin_owner.trace_on_tdo, 1'h0);
    chk(tdo_out, 1'h0);
  endtask

  task automatic t_route();
    ap_req = 1'h1;
    dp_ap_access = 1'h1;
    for (int i = 0; i < 3; i++) begin
      access_port_select = 8'(i);
      wclk(3);
      chk(ap_route, {i == 0, i == 1});
    end
    chk(sys_ctrl.cpu_clk_restore_req, 1'h1);
  endtask

  // test clock held low across the external reset asks for the core to stay held
  task automatic t_core_hold();
    rstn = 1'h0;
    i_probe.stand(1'h0);
    wclk(5);
    rstn = 1'h1;
    wclk(4);
    reset_n_pin = 1'h0;
    wclk(6);
    chk(sys_ctrl.system_rc_oscillator_clock_as_cpu_clk, 1'h1);
    reset_n_pin = 1'h1;
    wclk(8);
    chk(sys_ctrl.core_reset_req, 1'h1);
    chk(debugger_attached, 1'h0);
    system_manager_access_port_release_core = 1'h1;
    wclk(2);
    system_manager_access_port_release_core = 1'h0;
    wclk(2);
    chk(sys_ctrl.core_reset_req, 1'h0);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    {backup_mode, dp_swdio_out, dp_swdio_oe, dp_tdo, bscan_tdo, trace_data, trace_enable} = '0;
    {dp_ap_access, ap_req, system_manager_access_port_release_core} = '0;
    access_port_select = 8'h00;
    wclk(5);
    rstn = 1'h1;
    wclk(4);
    t_attach();
    t_tdo_select();
    t_switch();
    t_route();
    t_core_hold();
    end_of_test();
  end
endmodule // debug_port_attach_and_select_tb

`default_nettype wire
